/* File: rtl/sstf_pkg.sv */
package sstf_pkg;
  // ==========================================================
  // Register map.
  localparam logic [7:0] OFS_TX_CLOCK_MODE = 8'h00;
  localparam logic [7:0] OFS_TX_FRAME_MODE = 8'h04;
  localparam logic [7:0] OFS_TX_HOLD       = 8'h08;
  localparam logic [7:0] OFS_TX_TAG        = 8'h0C;
  localparam logic [7:0] OFS_RX_HOLDING    = 8'h10;
  localparam logic [7:0] OFS_STATUS        = 8'h14;
  localparam logic [7:0] OFS_CONTROL       = 8'h18;
  localparam logic [7:0] OFS_CLOCK_DIV     = 8'h1C;
  // ==========================================================
  // Clock mode fields.
  localparam int CKS_LSB = 0;
  localparam int CKO_LSB = 2;
  localparam int CKI_BIT = 5;
  localparam int CKG_LSB = 6;
  localparam int STA_LSB = 8;
  localparam int DLY_LSB = 16;
  localparam int PER_LSB = 24;
  // ==========================================================
  // Frame mode fields.
  localparam int LEN_LSB  = 0;
  localparam int IDL_BIT  = 5;
  localparam int MSB_BIT  = 7;
  localparam int NB_LSB   = 8;
  localparam int FSL_LSB  = 16;
  localparam int FSO_LSB  = 20;
  localparam int FSD_BIT  = 23;
  localparam int FSE_BIT  = 24;
  localparam int FSX_LSB  = 28;
  // ==========================================================
  // Status and control bits.
  localparam int ST_READY = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_SYNC  = 10;
  localparam int ST_EN    = 16;
  localparam int CR_EN    = 8;
  localparam int CR_DIS   = 9;
  // ==========================================================
  // Encodings.
  localparam logic [1:0] SRC_DIV   = 2'h0;
  localparam logic [1:0] SRC_RX    = 2'h1;
  localparam logic [1:0] SRC_PIN   = 2'h2;
  localparam logic [2:0] CKO_CONT  = 3'h1;
  localparam logic [2:0] CKO_XFER  = 3'h2;
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_LOW  = 2'h1;
  localparam logic [1:0] GATE_HIGH = 2'h2;
  localparam logic [2:0] FS_NEG    = 3'h1;
  localparam logic [2:0] FS_POS    = 3'h2;
  localparam logic [2:0] FS_LOW    = 3'h3;
  localparam logic [2:0] FS_HIGH   = 3'h4;
  localparam logic [2:0] FS_TOG    = 3'h5;
  localparam logic [1:0] DMA_BYTE  = 2'h0;
  localparam logic [1:0] DMA_HALF  = 2'h1;
  localparam logic [1:0] DMA_WORD  = 2'h2;
  localparam logic [4:0] LEN_BYTE  = 5'h07;
  localparam logic [4:0] LEN_HALF  = 5'h0F;
  localparam logic [4:0] WORD_MSB  = 5'h1F;
  localparam logic [4:0] TAG_BITS  = 5'h10;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_DATA, ST_WAIT} sstf_state_e;
endpackage

/* File: rtl/sstf_top.sv */
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Operation
// - Bit clock source: divider, receive clock, pin.
// - Clock pin: input, continuous, or transfer-only.
// - Inversion swaps shift and sample edges.
// - Inversion never alters driven clock polarity.
// - Gating: none, sync-low only, sync-high only.
// - Mode zero: start on write, back-to-back.
// - Start on receiver, sync level or edge.
// - Nonzero delay precedes first data bits.
// - Period signal every 2*(period+1) clocks.
// - Word holds length field plus one bits.
// - Length field selects DMA transfer size.
// - Idle data line drives idle level.
// - Bit order bit selects MSB or LSB.
// - Frame carries word count plus one words.
// - Sync lasts low+16*high+1 clock periods.
// - Sync length sets tag bits shifted.
// - Sync pin shape: input, pulse, level, toggle.
// - Tag shifted during sync, else idle level.
// - Sync flag on chosen frame-sync edge.
// - Receive holding word right-aligned.
// - Sync flag cleared by status read.
module sstf_top
  import sstf_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // Register port.
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Receiver side.
  input  wire logic        I_RX_START,
  input  wire logic        I_RX_WORD_VALID,
  input  wire logic [31:0] I_RX_WORD_VALUE,
  input  wire logic [4:0]  I_RX_WORD_BITS_MINUS_ONE,
  // Pins.
  input  wire logic        I_TX_CLOCK_PIN,
  input  wire logic        I_RX_CLOCK_PIN,
  input  wire logic        I_TX_SYNC_PIN,
  output logic             O_TX_CLOCK_PIN,
  output logic             O_TX_CLOCK_PIN_OE,
  output logic             O_TX_SYNC_PIN,
  output logic             O_TX_SYNC_PIN_OE,
  output logic             O_TX_DATA_PIN,
  output logic [1:0]       O_DMA_SIZE
);
  // ==========================================================
  // Pin synchronisers.
  logic [2:0] pin_raw;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  assign pin_raw = {I_TX_SYNC_PIN, I_RX_CLOCK_PIN, I_TX_CLOCK_PIN};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= pin_raw[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end
  logic tk_s;
  logic rk_s;
  logic tf_s;
  assign tk_s = sync_q[0];
  assign rk_s = sync_q[1];
  assign tf_s = sync_q[2];
  // ==========================================================
  // Registers.
  logic [31:0] cmode_q, cmode_d;
  logic [31:0] fmode_q, fmode_d;
  logic [31:0] hold_q, hold_d;
  logic [15:0] tag_q, tag_d;
  logic [31:0] rxh_q, rxh_d;
  logic [11:0] div_q, div_d;
  logic        full_q, full_d;
  logic        txen_q, txen_d;
  logic        synf_q, synf_d;
  logic [31:0] rdata_d;
  logic [1:0]  tx_clock_source;
  logic [2:0]  tx_clock_pin_mode;
  logic        tx_clock_invert;
  logic [1:0]  tx_clock_gate;
  logic [3:0]  start_sel;
  logic [7:0]  dly;
  logic [7:0]  period;
  logic [4:0]  len;
  logic        idle_lvl;
  logic        msb_first_order;
  logic [3:0]  nb;
  logic [8:0]  sync_len_low;
  logic [2:0]  sync_output_shape;
  logic        sync_tag_enable;
  logic        sync_flag_edge;
  assign tx_clock_source       = cmode_q[CKS_LSB +: 2];
  assign tx_clock_pin_mode       = cmode_q[CKO_LSB +: 3];
  assign tx_clock_invert       = cmode_q[CKI_BIT];
  assign tx_clock_gate       = cmode_q[CKG_LSB +: 2];
  assign start_sel = cmode_q[STA_LSB +: 4];
  assign dly       = cmode_q[DLY_LSB +: 8];
  assign period    = cmode_q[PER_LSB +: 8];
  assign len       = fmode_q[LEN_LSB +: 5];
  assign idle_lvl  = fmode_q[IDL_BIT];
  assign msb_first_order      = fmode_q[MSB_BIT];
  assign nb        = fmode_q[NB_LSB +: 4];
  assign sync_output_shape      = fmode_q[FSO_LSB +: 3];
  assign sync_tag_enable     = fmode_q[FSD_BIT];
  assign sync_flag_edge    = fmode_q[FSE_BIT];
  // Sync length in bit-clock periods.
  assign sync_len_low = 9'(fmode_q[FSL_LSB +: 4]) + {1'b0, fmode_q[FSX_LSB +: 4], 4'h0} + 9'h001;
  // ==========================================================
  // Bit clock generation.
  logic [11:0] dcnt_q, dcnt_d;
  logic        dlvl_q, dlvl_d;
  logic        clk_prev_q;
  logic        clk_lvl;
  logic        gate_ok;
  logic        rise;
  logic        fall;
  logic        shift_en;
  logic        smp_en;
  always_comb begin
    dcnt_d = dcnt_q;
    dlvl_d = dlvl_q;
    if (div_q != '0) begin
      if (dcnt_q >= div_q - 12'h001) begin
        dcnt_d = '0;
        dlvl_d = ~dlvl_q;
      end else begin
        dcnt_d = dcnt_q + 12'h001;
      end
    end
    unique case (tx_clock_source)
      SRC_DIV: clk_lvl = dlvl_q;
      SRC_RX:  clk_lvl = rk_s;
      SRC_PIN: clk_lvl = tk_s;
      default: clk_lvl = 1'b0;
    endcase
    unique case (tx_clock_gate)
      GATE_NONE: gate_ok = 1'b1;
      GATE_LOW:  gate_ok = ~tf_s;
      GATE_HIGH: gate_ok = tf_s;
      default:   gate_ok = 1'b0;
    endcase
    rise     = gate_ok & clk_lvl & ~clk_prev_q;
    fall     = gate_ok & ~clk_lvl & clk_prev_q;
    shift_en = tx_clock_invert ? rise : fall;
    smp_en   = tx_clock_invert ? fall : rise;
  end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      dcnt_q     <= '0;
      dlvl_q     <= 1'b0;
      clk_prev_q <= 1'b0;
    end else begin
      dcnt_q     <= dcnt_d;
      dlvl_q     <= dlvl_d;
      clk_prev_q <= clk_lvl;
    end
  end
  // ==========================================================
  // Start triggers and period divider.
  logic [8:0] pcnt_q, pcnt_d;
  logic       tfs_q, tfs_d;
  logic       trig_q, trig_d;
  logic       ptick;
  logic       pin_trig;
  logic       go;
  logic       take;
  sstf_state_e st_q, st_d;
  always_comb begin
    pcnt_d = pcnt_q;
    ptick  = 1'b0;
    tfs_d  = tfs_q;
    if (period == '0) begin
      pcnt_d = '0;
    end else if (rise) begin
      if (pcnt_q >= {period, 1'b1}) begin
        pcnt_d = '0;
        ptick  = 1'b1;
      end else begin
        pcnt_d = pcnt_q + 9'h001;
      end
    end
    if (smp_en) begin
      tfs_d = tf_s;
    end
    unique case (start_sel)
      4'h2:    pin_trig = ~tf_s;
      4'h3:    pin_trig = tf_s;
      4'h4:    pin_trig = tfs_q & ~tf_s;
      4'h5:    pin_trig = ~tfs_q & tf_s;
      4'h6,
      4'h7:    pin_trig = tfs_q ^ tf_s;
      default: pin_trig = 1'b0;
    endcase
    // A trigger seen between shift edges is held until consumed.
    trig_d = trig_q;
    if (take) begin
      trig_d = 1'b0;
    end
    if ((start_sel == 4'h1 && I_RX_START) || (smp_en && pin_trig) || ptick) begin
      trig_d = 1'b1;
    end
    go = txen_q & full_q & (start_sel == 4'h0 || trig_q);
  end
  assign take = shift_en & (st_q == ST_IDLE) & go;
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pcnt_q <= '0;
      tfs_q  <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_d;
      tfs_q  <= tfs_d;
      trig_q <= trig_d;
    end
  end
  // ==========================================================
  // Transmit sequencer.
  logic [31:0] dsh_q, dsh_d;
  logic [31:0] tsh_q, tsh_d;
  logic [4:0]  bcnt_q, bcnt_d;
  logic [3:0]  wcnt_q, wcnt_d;
  logic [7:0]  dcnt2_q, dcnt2_d;
  logic [8:0]  scnt_q, scnt_d;
  logic        tog_q, tog_d;
  logic        load;
  logic        word_end;
  logic [4:0]  tag_n;
  logic [31:0] word_al;
  always_comb begin
    st_d    = st_q;
    dsh_d   = dsh_q;
    tsh_d   = tsh_q;
    bcnt_d  = bcnt_q;
    wcnt_d  = wcnt_q;
    dcnt2_d = dcnt2_q;
    scnt_d  = scnt_q;
    tog_d   = tog_q;
    load    = 1'b0;
    tag_n   = (sync_len_low > 9'(TAG_BITS)) ? TAG_BITS : sync_len_low[4:0];
    word_al = msb_first_order ? (hold_q << (WORD_MSB - len)) : hold_q;
    word_end = (bcnt_q == '0);
    if (shift_en) begin
      if (scnt_q != '0) begin
        scnt_d = scnt_q - 9'h001;
        tsh_d  = msb_first_order ? (tsh_q << 1) : (tsh_q >> 1);
      end
      unique case (st_q)
        ST_IDLE: begin
          if (go) begin
            scnt_d = sync_len_low;
            tsh_d  = msb_first_order ? ({tag_q, 16'h0000} << (TAG_BITS - tag_n)) : {16'h0000, tag_q};
            tog_d  = ~tog_q;
            wcnt_d = nb;
            if (dly != '0) begin
              dcnt2_d = dly;
              st_d    = ST_DELAY;
            end else begin
              load = 1'b1;
            end
          end
        end
        ST_DELAY: begin
          dcnt2_d = dcnt2_q - 8'h01;
          if (dcnt2_q == 8'h01) begin
            load = full_q;
            st_d = full_q ? ST_DATA : ST_WAIT;
          end
        end
        ST_DATA: begin
          dsh_d  = msb_first_order ? (dsh_q << 1) : (dsh_q >> 1);
          bcnt_d = bcnt_q - 5'h01;
          if (word_end) begin
            if (wcnt_q != '0) begin
              wcnt_d = wcnt_q - 4'h1;
              load   = full_q;
              st_d   = full_q ? ST_DATA : ST_WAIT;
            end else if (start_sel == 4'h0 && txen_q && full_q) begin
              wcnt_d = nb;
              scnt_d = sync_len_low;
              tsh_d  = msb_first_order ? ({tag_q, 16'h0000} << (TAG_BITS - tag_n)) : {16'h0000, tag_q};
              tog_d  = ~tog_q;
              load   = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          if (full_q) begin
            load = 1'b1;
          end
        end
      endcase
      if (load) begin
        dsh_d  = word_al;
        bcnt_d = len;
        st_d   = ST_DATA;
      end
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_q    <= ST_IDLE;
      dsh_q   <= '0;
      tsh_q   <= '0;
      bcnt_q  <= '0;
      wcnt_q  <= '0;
      dcnt2_q <= '0;
      scnt_q  <= '0;
      tog_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      dsh_q   <= dsh_d;
      tsh_q   <= tsh_d;
      bcnt_q  <= bcnt_d;
      wcnt_q  <= wcnt_d;
      dcnt2_q <= dcnt2_d;
      scnt_q  <= scnt_d;
      tog_q   <= tog_d;
    end
  end
  // ==========================================================
  // Pin drivers.
  logic xfer;
  logic sync_act;
  logic td_d, fs_d, fsoe_d, ck_d, ckoe_d;
  logic fs_seen, fs_prev_q;
  logic syn_evt;
  assign xfer     = (st_q != ST_IDLE);
  assign sync_act = (scnt_q != '0);
  always_comb begin
    // Data during a word wins over the tag tail when the delay is short.
    if (st_q == ST_DATA) begin
      td_d = msb_first_order ? dsh_q[31] : dsh_q[0];
    end else if (sync_act && sync_tag_enable) begin
      td_d = msb_first_order ? tsh_q[31] : tsh_q[0];
    end else begin
      td_d = idle_lvl;
    end
    fsoe_d = 1'b1;
    unique case (sync_output_shape)
      FS_NEG:  fs_d = ~sync_act;
      FS_POS:  fs_d = sync_act;
      FS_LOW:  fs_d = ~xfer;
      FS_HIGH: fs_d = xfer;
      FS_TOG:  fs_d = tog_q;
      default: begin
        fs_d   = 1'b0;
        fsoe_d = 1'b0;
      end
    endcase
    // The driven clock is the raw source level, before inversion.
    unique case (tx_clock_pin_mode)
      CKO_CONT: begin
        ck_d   = clk_lvl;
        ckoe_d = 1'b1;
      end
      CKO_XFER: begin
        ck_d   = clk_lvl & xfer;
        ckoe_d = 1'b1;
      end
      default: begin
        ck_d   = 1'b0;
        ckoe_d = 1'b0;
      end
    endcase
  end
  assign fs_seen = O_TX_SYNC_PIN_OE ? O_TX_SYNC_PIN : tf_s;
  assign syn_evt = sync_flag_edge ? (fs_prev_q & ~fs_seen) : (~fs_prev_q & fs_seen);
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TX_DATA_PIN     <= 1'b0;
      O_TX_SYNC_PIN     <= 1'b0;
      O_TX_SYNC_PIN_OE  <= 1'b0;
      O_TX_CLOCK_PIN    <= 1'b0;
      O_TX_CLOCK_PIN_OE <= 1'b0;
      fs_prev_q         <= 1'b0;
    end else begin
      O_TX_DATA_PIN     <= td_d;
      O_TX_SYNC_PIN     <= fs_d;
      O_TX_SYNC_PIN_OE  <= fsoe_d;
      O_TX_CLOCK_PIN    <= ck_d;
      O_TX_CLOCK_PIN_OE <= ckoe_d;
      fs_prev_q         <= fs_seen;
    end
  end
  // ==========================================================
  // Register port.
  logic [1:0]  dma_d;
  logic [32:0] rx_mask;
  always_comb begin
    cmode_d = cmode_q;
    fmode_d = fmode_q;
    hold_d  = hold_q;
    tag_d   = tag_q;
    div_d   = div_q;
    txen_d  = txen_q;
    full_d  = full_q & ~load;
    rx_mask = (33'h000000001 << (6'(I_RX_WORD_BITS_MINUS_ONE) + 6'h01)) - 33'h000000001;
    rxh_d   = I_RX_WORD_VALID ? (I_RX_WORD_VALUE & rx_mask[31:0]) : rxh_q;
    synf_d  = synf_q;
    if (I_RD && I_ADDR == OFS_STATUS) begin
      synf_d = 1'b0;
    end
    if (syn_evt) begin
      synf_d = 1'b1;
    end
    if (I_WR) begin
      unique case (I_ADDR)
        OFS_TX_CLOCK_MODE: cmode_d = I_WDATA;
        OFS_TX_FRAME_MODE: fmode_d = I_WDATA;
        OFS_TX_TAG:        tag_d   = I_WDATA[15:0];
        OFS_CLOCK_DIV:     div_d   = I_WDATA[11:0];
        OFS_TX_HOLD: begin
          hold_d = I_WDATA;
          full_d = 1'b1;
        end
        OFS_CONTROL: begin
          if (I_WDATA[CR_DIS]) begin
            txen_d = 1'b0;
          end else if (I_WDATA[CR_EN]) begin
            txen_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    rdata_d = '0;
    if (I_RD) begin
      unique case (I_ADDR)
        OFS_TX_CLOCK_MODE: rdata_d = cmode_q;
        OFS_TX_FRAME_MODE: rdata_d = fmode_q;
        OFS_TX_TAG:        rdata_d = {16'h0000, tag_q};
        OFS_RX_HOLDING:    rdata_d = rxh_q;
        OFS_CLOCK_DIV:     rdata_d = {20'h00000, div_q};
        OFS_STATUS: begin
          rdata_d[ST_READY] = ~full_q;
          rdata_d[ST_EMPTY] = ~full_q & ~xfer;
          rdata_d[ST_SYNC]  = synf_q;
          rdata_d[ST_EN]    = txen_q;
        end
        default: rdata_d = '0;
      endcase
    end
    if (len <= LEN_BYTE) begin
      dma_d = DMA_BYTE;
    end else if (len <= LEN_HALF) begin
      dma_d = DMA_HALF;
    end else begin
      dma_d = DMA_WORD;
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cmode_q    <= '0;
      fmode_q    <= '0;
      hold_q     <= '0;
      tag_q      <= '0;
      rxh_q      <= '0;
      div_q      <= '0;
      full_q     <= 1'b0;
      txen_q     <= 1'b0;
      synf_q     <= 1'b0;
      O_RDATA    <= '0;
      O_DMA_SIZE <= DMA_BYTE;
    end else begin
      cmode_q    <= cmode_d;
      fmode_q    <= fmode_d;
      hold_q     <= hold_d;
      tag_q      <= tag_d;
      rxh_q      <= rxh_d;
      div_q      <= div_d;
      full_q     <= full_d;
      txen_q     <= txen_d;
      synf_q     <= synf_d;
      O_RDATA    <= rdata_d;
      O_DMA_SIZE <= dma_d;
    end
  end
endmodule

/* File: testbench/sstf_codec.sv */
`timescale 1ns/1ps
// ==========================================================
// Codec model
module sstf_codec
(
  // Pins as seen on the board.
  input  wire logic i_clk_pin,
  input  wire logic i_sync_pin,
  input  wire logic i_data_pin,
  output logic      o_clk_drv,
  output logic      o_sync_drv
);
  logic [1:0] cap[$];

  // The codec is a pure slave, so released pins rest at their pull-down level.
  assign o_clk_drv  = 1'b0;
  assign o_sync_drv = 1'b0;

  // The device shifts on the falling edge, so the far side samples on the rising one.
  always @(posedge i_clk_pin) begin
    cap.push_back({i_sync_pin, i_data_pin});
  end
endmodule

/* File: testbench/sstf_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker
module sstf_chk
  import sstf_pkg::*;
(
  // Clock, reset and register port.
  input wire logic        I_MCLK,
  input wire logic        I_RESET_N,
  input wire logic [7:0]  I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  // Receiver side.
  input wire logic        I_RX_WORD_VALID,
  input wire logic [31:0] I_RX_WORD_VALUE,
  input wire logic [4:0]  I_RX_WORD_BITS_MINUS_ONE,
  // Pins.
  input wire logic        O_TX_CLOCK_PIN_OE,
  input wire logic        O_TX_SYNC_PIN_OE,
  input wire logic        O_TX_DATA_PIN,
  input wire logic [1:0]  O_DMA_SIZE
);
  logic [31:0] cm_q;
  logic [31:0] fm_q;
  logic [31:0] rx_q;
  logic        held_q;
  logic [1:0]  dma_exp;
  logic [2:0]  pm;
  logic [2:0]  fs;

  assign pm      = cm_q[4:2];
  assign fs      = fm_q[22:20];
  assign dma_exp = (fm_q[4:0] <= LEN_BYTE) ? DMA_BYTE : (fm_q[4:0] <= LEN_HALF) ? DMA_HALF : DMA_WORD;

  // Shadow copies keep only defined field bits, though the device stores and reads back every written bit, reserved ones included.
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cm_q   <= 32'h0;
      fm_q   <= 32'h0;
      rx_q   <= 32'h0;
      held_q <= 1'b0;
    end else begin
      if (I_WR && I_ADDR == OFS_TX_CLOCK_MODE) cm_q <= I_WDATA & 32'hFFFF_0FFF;
      if (I_WR && I_ADDR == OFS_TX_FRAME_MODE) fm_q <= I_WDATA & 32'hF1FF_0FBF;
      if (I_WR && I_ADDR == OFS_TX_HOLD) held_q <= 1'b1;
      if (I_RX_WORD_VALID) rx_q <= I_RX_WORD_VALUE & (32'hFFFF_FFFF >> (5'h1F - I_RX_WORD_BITS_MINUS_ONE));
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_rd(logic [7:0] a);
    I_RD && I_ADDR == a;
  endsequence

  AST_RDATA_REST: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("read data not zero outside answer");
  AST_UNMAPPED: assert property (I_RD && I_ADDR > OFS_CLOCK_DIV |=> O_RDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_CM_READBACK: assert property (s_rd(OFS_TX_CLOCK_MODE) |=> O_RDATA == $past(cm_q))
    else $error("clock mode readback wrong");
  AST_FM_READBACK: assert property (s_rd(OFS_TX_FRAME_MODE) |=> O_RDATA == $past(fm_q))
    else $error("frame mode readback wrong");
  AST_RX_ALIGNED: assert property (s_rd(OFS_RX_HOLDING) |=> O_RDATA == $past(rx_q))
    else $error("receive word not right aligned");
  AST_CLK_PIN_IN: assert property ((pm != CKO_CONT && pm != CKO_XFER) [*3] |-> !O_TX_CLOCK_PIN_OE)
    else $error("clock pin driven in input mode");
  AST_CLK_PIN_CONT: assert property ((pm == CKO_CONT) [*3] |-> O_TX_CLOCK_PIN_OE)
    else $error("continuous clock pin not driven");
  AST_SYNC_PIN_IN: assert property ((fs == 3'h0 || fs > FS_TOG) [*3] |-> !O_TX_SYNC_PIN_OE)
    else $error("sync pin driven in input mode");
  AST_SYNC_PIN_OUT: assert property ((fs >= FS_NEG && fs <= FS_TOG) [*3] |-> O_TX_SYNC_PIN_OE)
    else $error("sync pin not driven");
  AST_DMA_SIZE: assert property ($stable(fm_q[4:0]) [*2] |-> O_DMA_SIZE == dma_exp)
    else $error("transfer size wrong");
  AST_IDLE_LEVEL: assert property ((!held_q && !fm_q[FSD_BIT] && $stable(fm_q[IDL_BIT]))
    [*2] |-> O_TX_DATA_PIN == fm_q[IDL_BIT])
    else $error("data pin not at idle level");
endmodule

bind sstf_top sstf_chk i_chk (
  .I_MCLK (I_MCLK), .I_RESET_N (I_RESET_N), .I_ADDR (I_ADDR), .I_WDATA (I_WDATA),
  .I_WR (I_WR), .I_RD (I_RD), .O_RDATA (O_RDATA), .I_RX_WORD_VALID (I_RX_WORD_VALID),
  .I_RX_WORD_VALUE (I_RX_WORD_VALUE), .I_RX_WORD_BITS_MINUS_ONE (I_RX_WORD_BITS_MINUS_ONE),
  .O_TX_CLOCK_PIN_OE (O_TX_CLOCK_PIN_OE), .O_TX_SYNC_PIN_OE (O_TX_SYNC_PIN_OE),
  .O_TX_DATA_PIN (O_TX_DATA_PIN), .O_DMA_SIZE (O_DMA_SIZE)
);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  import sstf_pkg::*;
  logic        mclk      = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        rx_vld    = 1'b0;
  logic        rx_start  = 1'b0;
  logic [31:0] rx_val    = 32'h0;
  logic [4:0]  rx_len    = 5'h00;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        tk_o, tk_oe, tf_o, tf_oe, td, tk_drv, tf_drv;
  logic [1:0]  dma;
  wire         tk_pin    = tk_oe ? tk_o : tk_drv;
  wire         tf_pin    = tf_oe ? tf_o : tf_drv;
  int          n_errors  = 0;
  int          checks_done = 0;
  int          cycles    = 0;
  // The 4-bit tag pattern reads the same in either bit order.
  logic [3:0]  tag_bits  = 4'h9;
  logic [4:0]  lens[4]   = '{5'h07, 5'h08, 5'h0F, 5'h10};
  logic [1:0]  sizes[4]  = '{DMA_BYTE, DMA_HALF, DMA_HALF, DMA_WORD};
  logic [2:0]  modes[3]  = '{3'h0, 3'h1, 3'h3};
  logic [2:0]  shapes[3] = '{3'h0, FS_POS, 3'h6};
  logic        oes[3]    = '{1'b0, 1'b1, 1'b0};

  sstf_top i_dut (
    .I_MCLK (mclk), .I_RESET_N (rst_n), .I_ADDR (addr), .I_WDATA (wdata),
    .I_WR (wr), .I_RD (rd), .O_RDATA (rdata), .I_RX_START (rx_start),
    .I_RX_WORD_VALID (rx_vld), .I_RX_WORD_VALUE (rx_val), .I_RX_WORD_BITS_MINUS_ONE (rx_len),
    .I_TX_CLOCK_PIN (tk_pin), .I_RX_CLOCK_PIN (1'b0), .I_TX_SYNC_PIN (tf_pin),
    .O_TX_CLOCK_PIN (tk_o), .O_TX_CLOCK_PIN_OE (tk_oe), .O_TX_SYNC_PIN (tf_o),
    .O_TX_SYNC_PIN_OE (tf_oe), .O_TX_DATA_PIN (td), .O_DMA_SIZE (dma)
  );
  sstf_codec i_codec (
    .i_clk_pin (tk_pin), .i_sync_pin (tf_pin), .i_data_pin (td),
    .o_clk_drv (tk_drv), .o_sync_drv (tf_drv)
  );

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    rd_reg(a, rv);
    `CHK(rv, x)
  endtask

  task automatic rx_chk(input logic [4:0] len, input logic [31:0] v, x);
    rx_len <= len;
    rx_val <= v;
    rx_vld <= 1'b1;
    @(posedge mclk);
    rx_vld <= 1'b0;
    rd_chk(OFS_RX_HOLDING, x);
  endtask

  task automatic poll(input int b);
    int k;
    k  = 0;
    rv = 32'h0;
    while (rv[b] !== 1'b1 && k < 300) begin
      rd_reg(OFS_STATUS, rv);
      k++;
    end
    `CHK(rv[b], 1'b1)
  endtask

  // Waits for the sync pin level, then lets the flag settle before reading status.
  task automatic wait_tf(input logic lvl);
    int k;
    k = 0;
    while (tf_o !== lvl && k < 500) begin
      @(posedge mclk);
      k++;
    end
    repeat (2) @(posedge mclk);
    rd_reg(OFS_STATUS, rv);
  endtask

  task automatic frame(input logic [31:0] fm, input logic [7:0] dly, input logic [31:0] w0, w1);
    int          slen, nbit, nw, s, n, j;
    logic        e;
    logic [31:0] w;
    slen = fm[19:16] + 16 * fm[31:28] + 1;
    nbit = fm[4:0] + 1;
    nw   = fm[11:8] + 1;
    wr_reg(OFS_TX_CLOCK_MODE, {8'h00, dly, 16'h0004});
    wr_reg(OFS_TX_FRAME_MODE, fm);
    wr_reg(OFS_CONTROL, 32'h0000_0100);
    rd_reg(OFS_STATUS, rv);
    `CHK(rv[ST_EN], 1'b1)
    i_codec.cap.delete();
    wr_reg(OFS_TX_HOLD, w0);
    wait_tf(1'b1);
    `CHK(rv[ST_SYNC], ~fm[FSE_BIT])
    wait_tf(1'b0);
    `CHK(rv[ST_SYNC], fm[FSE_BIT])
    if (nw > 1) begin
      poll(ST_READY);
      wr_reg(OFS_TX_HOLD, w1);
    end
    poll(ST_EMPTY);
    repeat (60) @(posedge mclk);
    s = 0;
    while (s < i_codec.cap.size() && i_codec.cap[s][1] !== 1'b1) s++;
    n = 0;
    while (s + n < i_codec.cap.size() && i_codec.cap[s + n][1] === 1'b1) n++;
    `CHK(n, slen)
    for (int k = 0; k < dly + nw * nbit + 3; k++) begin
      j = k - dly;
      w = (j < nbit) ? w0 : w1;
      if (k < dly) e = (fm[FSD_BIT] && k < slen) ? tag_bits[k] : fm[IDL_BIT];
      else if (j < nw * nbit) e = fm[MSB_BIT] ? w[nbit - 1 - j % nbit] : w[j % nbit];
      else e = fm[IDL_BIT];
      `CHK(i_codec.cap[s + k][0], e)
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk(8'hFC, 32'h0);
    foreach (lens[i]) begin
      wr_reg(OFS_TX_FRAME_MODE, {27'h0, lens[i]});
      #1 `CHK(dma, sizes[i])
      @(posedge mclk);
      rd_chk(OFS_TX_FRAME_MODE, {27'h0, lens[i]});
    end
    foreach (modes[i]) begin
      wr_reg(OFS_TX_CLOCK_MODE, {27'h0, modes[i], 2'h0});
      wr_reg(OFS_TX_FRAME_MODE, {9'h0, shapes[i], 20'h00007});
      #1 `CHK(tk_oe, oes[i])
      `CHK(tf_oe, oes[i])
      @(posedge mclk);
      rd_chk(OFS_TX_CLOCK_MODE, {27'h0, modes[i], 2'h0});
    end
    rx_chk(5'h07, 32'hFFFF_FFA5, 32'h0000_00A5);
    rx_chk(5'h0F, 32'h1234_5678, 32'h0000_5678);
    wr_reg(OFS_CLOCK_DIV, 32'h0000_0003);
    wr_reg(OFS_TX_TAG, 32'h0000_9009);
    // Start delays cover the whole sync pulse, so no data lands on the tag.
    frame(32'h1021_0187, 8'h14, 32'h0000_00A5, 32'h0000_003C);
    frame(32'h01A3_002B, 8'h04, 32'h0000_05A3, 32'h0);
    // A word written under receiver-start selection must wait for the receiver pulse.
    wr_reg(OFS_TX_CLOCK_MODE, 32'h0000_0104);
    wr_reg(OFS_TX_HOLD, 32'h0000_0123);
    repeat (40) @(posedge mclk);
    rd_reg(OFS_STATUS, rv);
    `CHK(rv[ST_READY], 1'b0)
    rx_start <= 1'b1;
    @(posedge mclk);
    rx_start <= 1'b0;
    poll(ST_EMPTY);
    stop_test();
  end
endmodule
